/* design/ncp_channel.sv */
// one nand channel pin sequencer: command, address, write and read cycles
`timescale 1ns/100ps
`include "ncp_params.svh"
// Functional notes
// [R1] written bytes captured on write strobe rise
// [R2] address latch high across strobe rise
// [R3] command latch high while pulsing strobe
// [R4] flash keeps busy operation despite deselect
// [R5] read strobe fall; sample after access delay
// [R6] drive bus on writes, release on reads
// [R7] strap high 60 MHz, low 75 MHz
// [R8] factory test input held high normally
// [R9] never both latches; both low on data
module ncp_channel import ncp_pkg::*; #(
	parameter int FIFO_DEPTH = 16,
	parameter int WE_LOW_CYC = `NCP_WE_LOW_CYC,
	parameter int WE_HIGH_CYC = `NCP_WE_HIGH_CYC,
	parameter int READ_ACCESS_CYC = `NCP_READ_ACCESS_CYC,
	parameter int RE_HIGH_CYC = `NCP_RE_HIGH_CYC
) (
	input wire logic core_clk, // 100 MHz clock
	input wire logic arst_n, // async reset, active low
	input wire ncp_req_t req, // request: kind, bank, byte
	input wire logic req_valid, // request offered
	output logic req_ready, // request taken this cycle
	output logic [7:0] rd_data, // read byte at fifo head
	output logic rd_valid, // read byte available
	input wire logic rd_ready, // consumer takes read byte
	output logic busy, // a cycle is in progress
	input wire logic clock_rate_strap, // high 60, low 75 MHz
	input wire logic factory_test_select, // must stay high in use
	output logic [7:0] clock_rate_mhz, // rate chosen by strap
	output logic test_mode, // factory test strap low
	output logic we_n, // write strobe
	output logic re_n, // read strobe
	output logic ale, // address latch enable
	output logic cle, // command latch enable
	output logic [3:0] bank_select_n, // bank selects, active low
	output logic [7:0] dq_out, // bus drive value
	output logic dq_oe, // high while driving the bus
	input wire logic [7:0] dq_in // bus sampled value
);
	localparam int CW = 8;
	// refused at elaboration: a zero count would wrap the counter into a 256-cycle phase,
	// and the phase counter is only CW bits wide
	if (FIFO_DEPTH < 2 || WE_LOW_CYC < 1 || WE_HIGH_CYC < 1 || READ_ACCESS_CYC < 1 ||
		RE_HIGH_CYC < 1 || WE_LOW_CYC > 255 || READ_ACCESS_CYC > 255 || RE_HIGH_CYC > 255 ||
		WE_HIGH_CYC > 255) begin : g_bad_param
		$error("ncp_channel timing parameters out of range");
	end

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_WE_LOW = 5'h02,
		ST_WE_HIGH = 5'h04,
		ST_RE_LOW = 5'h08,
		ST_RE_HIGH = 5'h10
	} ncp_state_t;

	// active-low one-hot bank select decode of a request's bank number
	function automatic logic [3:0] bank_decode(input logic [1:0] b);
		bank_decode = ~(4'h1 << b);
	endfunction : bank_decode

	ncp_state_t st_reg, st_next;
	ncp_pins_t pins_reg, pins_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic req_ready_next, busy_next;
	logic fifo_in_valid, fifo_in_ready;
	logic [7:0] fifo_in_data;
	logic [7:0] rate_reg, rate_next;
	logic test_reg, test_next;

	// sequencer: one byte per request, strobe timing set by counters
	always_comb begin
		st_next = st_reg;
		pins_next = pins_reg;
		cnt_next = cnt_reg;
		req_ready_next = 1'b0;
		busy_next = (st_reg != ST_IDLE);
		fifo_in_valid = 1'b0;
		fifo_in_data = dq_in;
		unique case (st_reg)
			ST_IDLE: begin
				// a read is not taken without fifo room, so bytes are never dropped
				if (req_valid && !req_ready && (req.kind != NCP_RDATA || fifo_in_ready)) begin
					req_ready_next = 1'b1;
					busy_next = 1'b1;
					pins_next.bank_select_n = bank_decode(req.bank);
					pins_next.cle = (req.kind == NCP_CMD); // [R3] [R9]
					pins_next.ale = (req.kind == NCP_ADDR); // [R2] [R9]
					if (req.kind == NCP_RDATA) begin
						pins_next.dq_oe = 1'b0; // [R6]
						pins_next.re_n = 1'b0; // [R5]
						cnt_next = CW'(READ_ACCESS_CYC);
						st_next = ST_RE_LOW;
					end else begin
						pins_next.dq_oe = 1'b1; // [R6]
						pins_next.dq_out = req.data; // [R1]
						pins_next.we_n = 1'b0;
						cnt_next = CW'(WE_LOW_CYC);
						st_next = ST_WE_LOW;
					end
				end
			end
			ST_WE_LOW: begin
				cnt_next = cnt_reg - 1'b1;
				if (cnt_reg == CW'(1)) begin
					// rising edge while data, cle and ale still stand
					pins_next.we_n = 1'b1; // [R1] [R2] [R3]
					cnt_next = CW'(WE_HIGH_CYC);
					st_next = ST_WE_HIGH;
				end
			end
			ST_WE_HIGH: begin
				// bus and latches held through hold time after the rise
				cnt_next = cnt_reg - 1'b1;
				if (cnt_reg == CW'(1)) begin
					pins_next.cle = 1'b0; // [R9]
					pins_next.ale = 1'b0;
					pins_next.dq_oe = 1'b0; // [R6]
					st_next = ST_IDLE;
				end
			end
			ST_RE_LOW: begin
				cnt_next = cnt_reg - 1'b1;
				if (cnt_reg == CW'(1)) begin
					// access delay has elapsed since the falling edge
					fifo_in_valid = 1'b1; // [R5]
					pins_next.re_n = 1'b1;
					cnt_next = CW'(RE_HIGH_CYC);
					st_next = ST_RE_HIGH;
				end
			end
			ST_RE_HIGH: begin
				cnt_next = cnt_reg - 1'b1;
				if (cnt_reg == CW'(1)) begin
					st_next = ST_IDLE;
				end
			end
			default: begin
				st_next = ST_IDLE;
			end
		endcase
	end

	// the bank stays selected after a cycle; the flash keeps any busy work
	// going even once deselected, so no wait on busy is needed here [R4]

	// strap decode: registered so the outputs come from flops
	always_comb begin
		rate_next = clock_rate_strap ? 8'(`NCP_RATE_60_MHZ) : 8'(`NCP_RATE_75_MHZ); // [R7]
		test_next = !factory_test_select; // [R8]
	end

	// strap registers; reset shows the pulled-low default rate
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rate_reg <= 8'(`NCP_RATE_75_MHZ);
			test_reg <= 1'b0;
		end else begin
			rate_reg <= rate_next;
			test_reg <= test_next;
		end
	end

	// sequencer registers; reset parks strobes high and releases the bus
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= ST_IDLE;
			pins_reg <= '{we_n: 1'b1, re_n: 1'b1, ale: 1'b0, cle: 1'b0,
				bank_select_n: `NCP_BANK_IDLE, dq_out: 8'h00, dq_oe: 1'b0};
			cnt_reg <= '0;
			req_ready <= 1'b0;
			busy <= 1'b0;
		end else begin
			st_reg <= st_next;
			pins_reg <= pins_next;
			cnt_reg <= cnt_next;
			req_ready <= req_ready_next;
			busy <= busy_next;
		end
	end

	// read bytes buffered; a stalled consumer blocks further reads
	ncp_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.in_data(fifo_in_data),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.out_data(rd_data),
		.out_valid(rd_valid),
		.out_ready(rd_ready)
	);

	// pins straight from the pin register, strap outputs from the strap registers
	always_comb begin
		we_n = pins_reg.we_n;
		re_n = pins_reg.re_n;
		ale = pins_reg.ale;
		cle = pins_reg.cle;
		bank_select_n = pins_reg.bank_select_n;
		dq_out = pins_reg.dq_out;
		dq_oe = pins_reg.dq_oe;
		clock_rate_mhz = rate_reg;
		test_mode = test_reg;
	end
endmodule : ncp_channel

/* design/ncp_params.svh */
// timing counts and field constants for the nand channel pin interface
`ifndef NCP_PARAMS_SVH
`define NCP_PARAMS_SVH
`define NCP_CLK_PERIOD_NS 10
`define NCP_WE_LOW_NS 20
`define NCP_WE_LOW_CYC ((`NCP_WE_LOW_NS + `NCP_CLK_PERIOD_NS - 1) / `NCP_CLK_PERIOD_NS)
`define NCP_WE_HIGH_NS 20
`define NCP_WE_HIGH_CYC ((`NCP_WE_HIGH_NS + `NCP_CLK_PERIOD_NS - 1) / `NCP_CLK_PERIOD_NS)
`define NCP_READ_ACCESS_DELAY_NS 30
`define NCP_READ_ACCESS_CYC ((`NCP_READ_ACCESS_DELAY_NS + `NCP_CLK_PERIOD_NS - 1) / `NCP_CLK_PERIOD_NS)
`define NCP_RE_HIGH_NS 20
`define NCP_RE_HIGH_CYC ((`NCP_RE_HIGH_NS + `NCP_CLK_PERIOD_NS - 1) / `NCP_CLK_PERIOD_NS)
`define NCP_RATE_60_MHZ 60
`define NCP_RATE_75_MHZ 75
`define NCP_KIND_CMD 2'h0
`define NCP_KIND_ADDR 2'h1
`define NCP_KIND_WDATA 2'h2
`define NCP_KIND_RDATA 2'h3
`define NCP_BANKS 4
`define NCP_BANK_IDLE 4'hF
`endif

/* design/ncp_pkg.sv */
// types shared by the nand channel pin interface
package ncp_pkg;
	typedef enum logic [1:0] {
		NCP_CMD = 2'h0,
		NCP_ADDR = 2'h1,
		NCP_WDATA = 2'h2,
		NCP_RDATA = 2'h3
	} ncp_kind_t;
	typedef struct packed {
		ncp_kind_t kind;
		logic [1:0] bank;
		logic [7:0] data;
	} ncp_req_t;
	typedef struct packed {
		logic we_n;
		logic re_n;
		logic ale;
		logic cle;
		logic [3:0] bank_select_n;
		logic [7:0] dq_out;
		logic dq_oe;
	} ncp_pins_t;
endpackage : ncp_pkg

/* design/ncp_fifo.sv */
// parameterised valid/ready fifo for the read data path
`timescale 1ns/100ps
module ncp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic core_clk, // clock
	input wire logic arst_n, // async reset, active low
	input wire logic [WIDTH-1:0] in_data, // write word
	input wire logic in_valid, // write request
	output logic in_ready, // not full
	output logic [WIDTH-1:0] out_data, // head word
	output logic out_valid, // not empty
	input wire logic out_ready // drain request
);
	localparam int AW = $clog2(DEPTH);
	// refused at elaboration: the wrap-bit full test needs a power-of-two depth
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("ncp_fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
	logic push, pop;
	logic [WIDTH-1:0] head_reg, head_next;
	logic head_valid_reg, head_valid_next;
	// full when pointers differ only in the wrap bit; head word kept in flops
	always_comb begin
		in_ready = (wr_reg != {~rd_reg[AW], rd_reg[AW-1:0]});
		push = in_valid && in_ready;
		pop = head_valid_reg && out_ready;
		wr_next = push ? wr_reg + 1'b1 : wr_reg;
		rd_next = pop ? rd_reg + 1'b1 : rd_reg;
		head_valid_next = (wr_next != rd_next);
		// a word pushed into the slot that becomes the head bypasses the memory
		if (push && wr_reg[AW-1:0] == rd_next[AW-1:0]) begin
			head_next = in_data;
		end else begin
			head_next = mem[rd_next[AW-1:0]];
		end
		out_valid = head_valid_reg;
		out_data = head_reg;
	end
	// storage has no reset; only pointers and head registers carry state
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_reg[AW-1:0]] <= in_data;
		end
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			head_reg <= '0;
			head_valid_reg <= 1'b0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			head_reg <= head_next;
			head_valid_reg <= head_valid_next;
		end
	end
endmodule : ncp_fifo

/* tb/ncp_channel_monitor.sv */
// concurrent checks on the channel pin sequencer ports
`timescale 1ns/100ps
module ncp_monitor (
	input wire logic core_clk, // clock
	input wire logic arst_n, // async reset, active low
	input wire logic we_n, // write strobe
	input wire logic re_n, // read strobe
	input wire logic ale, // address latch
	input wire logic cle, // command latch
	input wire logic [3:0] bank_select_n, // bank selects
	input wire logic [7:0] dq_out, // bus drive value
	input wire logic dq_oe, // bus drive enable
	input wire logic clock_rate_strap, // rate strap
	input wire logic factory_test_select, // test strap
	input wire logic [7:0] clock_rate_mhz, // chosen rate
	input wire logic test_mode // test flag
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// strobe shapes: write low for two cycles, read low for three
	sequence s_we_pulse; !we_n ##1 we_n; endsequence
	sequence s_re_pulse; !re_n [*2] ##1 re_n; endsequence
	a_we_low_two: assert property ($fell(we_n) |=> s_we_pulse) else $error("write strobe width wrong");
	a_re_low_three: assert property ($fell(re_n) |=> s_re_pulse) else $error("read strobe width wrong");
	a_latch_held: assert property ($rose(we_n) |-> $stable(ale) && $stable(cle))
		else $error("latch moved at rise");
	// the byte must still stand, driven, at the edge the flash captures on
	a_data_held: assert property ($rose(we_n) |-> $stable(dq_out) && dq_oe)
		else $error("write byte moved at rise");
	a_no_dual_latch: assert property (!(ale && cle)) else $error("both latches high");
	a_drive_on_write: assert property (!we_n |-> dq_oe) else $error("bus not driven on write");
	a_release_on_read: assert property (!re_n |-> !dq_oe) else $error("bus driven on read");
	a_single_bank: assert property ($onehot0(~bank_select_n)) else $error("more than one bank selected");
	a_rate_from_strap: assert property (1'b1 |=> clock_rate_mhz == ($past(clock_rate_strap) ? 8'h3C : 8'h4B))
		else $error("rate does not follow strap");
	a_test_flag_set: assert property (1'b1 |=> test_mode == !$past(factory_test_select))
		else $error("test flag wrong");
endmodule : ncp_monitor

/* tb/ncp_flash_model.sv */
// behavioural flash device on the channel bus
`timescale 1ns/100ps
module ncp_flash_model #(
	parameter int ACC_NS = 25 // access delay, kept below the sampling point
) (
	input wire logic we_n, // write strobe
	input wire logic re_n, // read strobe
	input wire logic ale, // address latch
	input wire logic cle, // command latch
	input wire logic [3:0] bank_select_n, // bank selects
	input wire logic [7:0] dq, // resolved bus
	output logic [7:0] q // flash drive value
);
	logic [7:0] last_cmd;
	logic [7:0] last_addr;
	logic [7:0] last_data;
	logic [7:0] col;
	initial begin
		q = 8'h00;
		col = 8'h00;
	end
	// capture on strobe rise only while a bank is selected; a busy bank would keep
	// working if deselected, so nothing here aborts on a select going high
	always @(posedge we_n) begin
		if (bank_select_n != 4'hF) begin
			if (cle) last_cmd = dq;
			else if (ale) begin
				last_addr = dq;
				col = 8'h00;
			end else last_data = dq;
		end
	end
	// each read strobe fall hands out the next column after the access delay
	always @(negedge re_n) begin
		q = ~q;
		col = col + 8'h01;
		#(ACC_NS) q = 8'hA0 ^ (col - 8'h01);
	end
	// released bus shows no stale byte
	always @(posedge re_n) q = ~q;
endmodule : ncp_flash_model

/* tb/tb.sv */
// self-checking bench for the channel pin sequencer
`timescale 1ns/100ps
module tb;
	import ncp_pkg::*;
	typedef struct {ncp_kind_t kind; logic [1:0] bank; logic [7:0] data; logic [3:0] sel;} ncp_row_t;
	logic core_clk, arst_n, req_valid, req_ready, rd_valid, rd_ready, busy, ok;
	logic clock_rate_strap, factory_test_select, test_mode, we_n, re_n, ale, cle, dq_oe;
	logic [7:0] rd_data, clock_rate_mhz, dq_out, fq, dq_bus;
	logic [3:0] bank_select_n;
	ncp_req_t req;
	int err_count, checks_done, cycles;
	ncp_row_t rows [5] = '{'{NCP_CMD, 2'h0, 8'h00, 4'hE}, '{NCP_ADDR, 2'h1, 8'h12, 4'hD}, '{NCP_ADDR, 2'h2, 8'h34, 4'hB},
		'{NCP_WDATA, 2'h3, 8'h5A, 4'h7}, '{NCP_CMD, 2'h0, 8'h30, 4'hE}};
	assign dq_bus = dq_oe ? dq_out : fq; // bus level from both drivers
	ncp_channel dut_u (.core_clk, .arst_n, .req, .req_valid, .req_ready, .rd_data, .rd_valid, .rd_ready, .busy,
		.clock_rate_strap, .factory_test_select, .clock_rate_mhz, .test_mode, .we_n, .re_n, .ale, .cle,
		.bank_select_n, .dq_out, .dq_oe, .dq_in(dq_bus));
	ncp_flash_model flash_u (.we_n, .re_n, .ale, .cle, .bank_select_n, .dq(dq_bus), .q(fq));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input logic c, input string m);
		checks_done++;
		if (c !== 1'b1) begin
			err_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	// offer one request, give up after a bounded wait, then let the cycle finish
	task automatic send(input ncp_kind_t k, input logic [1:0] b, input logic [7:0] d, output logic tk);
		req = '{k, b, d};
		req_valid = 1'b1;
		tk = 1'b0;
		repeat (20) begin
			@(negedge core_clk);
			if (req_ready === 1'b1) begin
				tk = 1'b1;
				break;
			end
		end
		req_valid = 1'b0;
		@(negedge core_clk);
		while (busy === 1'b1) @(negedge core_clk);
	endtask : send
	task automatic finish_test();
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			finish_test();
		end
	end
	initial begin
		arst_n = 1'b0;
		req = '0;
		req_valid = 1'b0;
		rd_ready = 1'b0;
		clock_rate_strap = 1'b0;
		factory_test_select = 1'b1;
		err_count = 0;
		checks_done = 0;
		repeat (12) @(negedge core_clk);
		chk(we_n === 1'b1 && bank_select_n === 4'hF && clock_rate_mhz === 8'h4B, "reset pin state");
		arst_n = 1'b1;
		foreach (rows[i]) begin
			send(rows[i].kind, rows[i].bank, rows[i].data, ok);
			chk(ok && bank_select_n === rows[i].sel, "bank select");
			case (rows[i].kind)
				NCP_CMD: chk(flash_u.last_cmd === rows[i].data, "command byte");
				NCP_ADDR: chk(flash_u.last_addr === rows[i].data, "address byte");
				default: chk(flash_u.last_data === rows[i].data, "data byte");
			endcase
		end
		// fill the read buffer with the consumer stalled; the seventeenth is refused
		send(NCP_ADDR, 2'h1, 8'h00, ok);
		for (int i = 0; i < 17; i++) begin
			send(NCP_RDATA, 2'h1, 8'h00, ok);
			chk(ok === (i < 16), "read take or refusal");
		end
		for (int i = 0; i < 16; i++) begin
			chk(rd_valid === 1'b1 && rd_data === (8'hA0 ^ 8'(i)), "read byte order");
			rd_ready = 1'b1;
			@(negedge core_clk);
		end
		rd_ready = 1'b0;
		chk(rd_valid === 1'b0, "buffer drained");
		clock_rate_strap = 1'b1;
		factory_test_select = 1'b0;
		repeat (2) @(negedge core_clk);
		chk(clock_rate_mhz === 8'h3C && test_mode === 1'b1, "strap readout");
		factory_test_select = 1'b1;
		// reset in mid-write must park strobes and release the bus
		req = '{NCP_WDATA, 2'h2, 8'hC3};
		req_valid = 1'b1;
		repeat (2) @(negedge core_clk);
		arst_n = 1'b0;
		req_valid = 1'b0;
		@(negedge core_clk);
		chk(we_n === 1'b1 && dq_oe === 1'b0 && busy === 1'b0 && clock_rate_mhz === 8'h4B, "reset mid write");
		arst_n = 1'b1;
		repeat (3) @(negedge core_clk);
		chk(clock_rate_mhz === 8'h3C && test_mode === 1'b0, "strap after reset");
		// the sequencer must take a fresh request once out of the second reset
		send(NCP_CMD, 2'h2, 8'h70, ok);
		chk(ok && bank_select_n === 4'hB && flash_u.last_cmd === 8'h70, "command after reset");
		finish_test();
	end
endmodule : tb
bind ncp_channel ncp_monitor mon_u (.core_clk, .arst_n, .we_n, .re_n, .ale, .cle, .bank_select_n, .dq_out, .dq_oe,
	.clock_rate_strap, .factory_test_select, .clock_rate_mhz, .test_mode);
